// ==== dual_fan_pwm_control.sv ====
// Dual fan PWM control block with APB register slave
//
// Function
// - Reserved offsets 0x52-0x55 read zero
// - Fan A bit0 forces high, else duty
// - Duty is high steps out of 64
// - Fan A rate from select and source
// - Config bit 2 doubles fan A rate
// - Fan B control behaves like fan A
// - Fan B rate from select and source
// - Config bit 3 doubles fan B rate
// - Multiplier zero keeps rate, one doubles
`timescale 1ns/1ns
module dual_fan_pwm_control #(
    parameter int DIV_W = fan_pwm_pkg::DIV_W
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             fan_pwm_out_a,
    output logic             fan_pwm_out_b
);
    logic [7:0]       fan_pwm_ctrl_a;
    logic [7:0]       fan_pwm_ctrl_b;
    logic [7:0]       fan_clock_config;
    logic [7:0]       index;
    logic             addr_ok;
    logic             known;
    logic             wr_en;
    logic [DIV_W-1:0] div_a;
    logic [DIV_W-1:0] div_b;

    ////////////////////////////////////////////////////////////////////////
    // Address decode: word aligned, index in bits 9:2
    assign index   = paddr[fan_pwm_pkg::ADDR_W-1:2];
    assign addr_ok = (paddr[31:fan_pwm_pkg::ADDR_W] == '0) && (paddr[1:0] == 2'b00);
    assign known   = addr_ok && (index >= fan_pwm_pkg::IDX_RESERVED_A)
                     && (index <= fan_pwm_pkg::IDX_FAN_CLOCK_CONFIG);
    assign wr_en   = psel && penable && pwrite && known && pstrb[0];

    ////////////////////////////////////////////////////////////////////////
    // Fan control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_pwm_ctrl_a <= fan_pwm_pkg::FAN_CTRL_RESET;
            fan_pwm_ctrl_b <= fan_pwm_pkg::FAN_CTRL_RESET;
        end else if (wr_en) begin
            if (index == fan_pwm_pkg::IDX_FAN_PWM_CTRL_A) begin
                fan_pwm_ctrl_a <= pwdata[7:0];
            end
            if (index == fan_pwm_pkg::IDX_FAN_PWM_CTRL_B) begin
                fan_pwm_ctrl_b <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared clock configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fan_clock_config <= fan_pwm_pkg::FAN_CFG_RESET;
        end else if (wr_en && index == fan_pwm_pkg::IDX_FAN_CLOCK_CONFIG) begin
            fan_clock_config <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and response, one wait-free access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            pslverr <= !known;
            prdata  <= '0;
            if (!pwrite && known) begin
                case (index)
                    fan_pwm_pkg::IDX_FAN_PWM_CTRL_A: begin
                        prdata <= {24'h00_0000, fan_pwm_ctrl_a};
                    end
                    fan_pwm_pkg::IDX_FAN_PWM_CTRL_B: begin
                        prdata <= {24'h00_0000, fan_pwm_ctrl_b};
                    end
                    fan_pwm_pkg::IDX_FAN_CLOCK_CONFIG: begin
                        prdata <= {24'h00_0000, fan_clock_config};
                    end
                    default: begin
                        prdata <= '0;
                    end
                endcase
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Step divider for one fan from source, select and multiplier
    function automatic logic [DIV_W-1:0] rate_div(input logic src, input logic sel,
                                                  input logic mult);
        logic [DIV_W-1:0] base;
        base = '0;
        case ({src, sel})
            2'b00:   base = DIV_W'(fan_pwm_pkg::DIV_SRC0_SEL0);
            2'b01:   base = DIV_W'(fan_pwm_pkg::DIV_SRC0_SEL1);
            2'b10:   base = DIV_W'(fan_pwm_pkg::DIV_SRC1_SEL0);
            default: base = DIV_W'(fan_pwm_pkg::DIV_SRC1_SEL1);
        endcase
        return mult ? (base >> 1) : base;
    endfunction

    assign div_a = rate_div(fan_clock_config[fan_pwm_pkg::SRC_SEL_A_BIT],
                            fan_pwm_ctrl_a[fan_pwm_pkg::CLK_SEL_BIT],
                            fan_clock_config[fan_pwm_pkg::MULT_A_BIT]);
    assign div_b = rate_div(fan_clock_config[fan_pwm_pkg::SRC_SEL_B_BIT],
                            fan_pwm_ctrl_b[fan_pwm_pkg::CLK_SEL_BIT],
                            fan_clock_config[fan_pwm_pkg::MULT_B_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // Channels
    fan_pwm_channel #(.DIV_W(DIV_W), .DUTY_W(fan_pwm_pkg::DUTY_W)) u_chan_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .force_high (fan_pwm_ctrl_a[fan_pwm_pkg::FORCE_HIGH_BIT]),
        .duty       (fan_pwm_ctrl_a[fan_pwm_pkg::DUTY_LSB +: fan_pwm_pkg::DUTY_W]),
        .step_div   (div_a),
        .pwm_out    (fan_pwm_out_a)
    );

    fan_pwm_channel #(.DIV_W(DIV_W), .DUTY_W(fan_pwm_pkg::DUTY_W)) u_chan_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .force_high (fan_pwm_ctrl_b[fan_pwm_pkg::FORCE_HIGH_BIT]),
        .duty       (fan_pwm_ctrl_b[fan_pwm_pkg::DUTY_LSB +: fan_pwm_pkg::DUTY_W]),
        .step_div   (div_b),
        .pwm_out    (fan_pwm_out_b)
    );
endmodule // dual_fan_pwm_control

// ==== fan_model.sv ====
// Fan model: measures period and high time of one PWM pin
`timescale 1ns/1ns
module fan_model (
    input wire logic pclk,
    input wire logic pin,
    output int       rises,
    output int       period,
    output int       high
);
    int cnt = 0;
    int hc = 0;
    logic last = 1'b0;
    initial {rises, period, high} = 0;
    always @(posedge pclk) begin
        if (pin && !last) begin
            period = cnt;
            high = hc;
            cnt = 1;
            hc = 1;
            rises++;
        end else begin
            cnt++;
            hc += int'(pin);
        end
        last = pin;
    end
endmodule // fan_model

// ==== fan_pwm_channel.sv ====
// One PWM channel: rate divider, 6-bit counter and pin register
`timescale 1ns/1ns
module fan_pwm_channel #(
    parameter int DIV_W  = fan_pwm_pkg::DIV_W,
    parameter int DUTY_W = fan_pwm_pkg::DUTY_W
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              force_high,
    input  wire logic [DUTY_W-1:0] duty,
    input  wire logic [DIV_W-1:0]  step_div,
    output logic                   pwm_out
);
    logic [DIV_W-1:0]  div_count;
    logic              step;
    logic [DUTY_W-1:0] phase;

    ////////////////////////////////////////////////////////////////////////
    // Step enable at the selected fan rate
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_count <= '0;
            step      <= 1'b0;
        end else if (div_count >= step_div - 1'b1) begin
            div_count <= '0;
            step      <= 1'b1;
        end else begin
            div_count <= div_count + 1'b1;
            step      <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Free-running phase counter, 64 steps per period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= '0;
        end else if (step) begin
            phase <= phase + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin: forced high, else high while phase is below duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 1'b0;
        end else if (force_high) begin
            pwm_out <= 1'b1;
        end else begin
            pwm_out <= (phase < duty);
        end
    end
endmodule // fan_pwm_channel

// ==== fan_pwm_checker_properties.sv ====
// Concurrent checks on the ports of the dual fan PWM block
`timescale 1ns/1ns
module fan_pwm_checker (
    input wire logic        pclk, presetn, psel, penable, pwrite,
    input wire logic [31:0] paddr, pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready, pslverr, fan_pwm_out_a, fan_pwm_out_b
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] sa, sb;
    wire logic [7:0] ix = paddr[9:2];
    wire logic ok = paddr[31:10] == 22'h0 && paddr[1:0] == 2'h0;
    wire logic wr = psel && penable && pready && pwrite && pstrb[0] && ok;
    wire logic rd = pready && !pwrite && ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sa <= 8'h00;
            sb <= 8'h00;
        end else if (wr && ix == 8'h56) begin
            sa <= pwdata[7:0];
        end else if (wr && ix == 8'h57) begin
            sb <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    rsvd_read_zero_a: assert property (rd && ix inside {[8'h52:8'h55]} |-> prdata == 32'h0)
        else $error("reserved read not zero");
    rsvd_no_err_a: assert property (pready && ok && ix inside {[8'h52:8'h55]} |-> !pslverr)
        else $error("reserved access flagged");
    ctrl_a_read_a: assert property (rd && ix == 8'h56 |-> prdata == {24'h0, sa})
        else $error("fan a register readback wrong");
    force_a_high_a: assert property ($past(sa[0]) |-> fan_pwm_out_a)
        else $error("fan a not forced high");
    zero_a_low_a: assert property ($past(sa[6:0]) == 7'h0 |-> !fan_pwm_out_a)
        else $error("fan a high at zero duty");
    force_b_high_a: assert property ($past(sb[0]) |-> fan_pwm_out_b)
        else $error("fan b not forced high");
    zero_b_low_a: assert property ($past(sb[6:0]) == 7'h0 |-> !fan_pwm_out_b)
        else $error("fan b high at zero duty");
    reset_low_a: assert property ($rose(presetn) |-> !fan_pwm_out_a && !fan_pwm_out_b)
        else $error("fan pins high after reset");
endmodule // fan_pwm_checker

// ==== fan_pwm_pkg.sv ====
// Package: register map, fields, reset values and timing for the dual fan PWM block
package fan_pwm_pkg;
    // Register indices (printed offsets); byte address is four times the index
    localparam logic [7:0] IDX_RESERVED_A   = 8'h52;
    localparam logic [7:0] IDX_RESERVED_B   = 8'h53;
    localparam logic [7:0] IDX_RESERVED_C   = 8'h54;
    localparam logic [7:0] IDX_RESERVED_D   = 8'h55;
    localparam logic [7:0] IDX_FAN_PWM_CTRL_A = 8'h56;
    localparam logic [7:0] IDX_FAN_PWM_CTRL_B = 8'h57;
    localparam logic [7:0] IDX_FAN_CLOCK_CONFIG = 8'h58;
    localparam int         ADDR_W           = 10;
    // Fan control register fields
    localparam int         FORCE_HIGH_BIT   = 0;
    localparam int         DUTY_LSB         = 1;
    localparam int         DUTY_W           = 6;
    localparam int         CLK_SEL_BIT      = 7;
    // Shared fan clock configuration fields
    localparam int         SRC_SEL_A_BIT    = 0;
    localparam int         SRC_SEL_B_BIT    = 1;
    localparam int         MULT_A_BIT       = 2;
    localparam int         MULT_B_BIT       = 3;
    // Reset values
    localparam logic [7:0] FAN_CTRL_RESET   = 8'h00;
    localparam logic [7:0] FAN_CFG_RESET    = 8'h50;
    // Clock and base PWM step rates (one counter step per tick)
    localparam int         PCLK_HZ          = 25_000_000;
    localparam int         STEP_HZ_SRC0_SEL0 = 1_000_000;
    localparam int         STEP_HZ_SRC0_SEL1 = 500_000;
    localparam int         STEP_HZ_SRC1_SEL0 = 250_000;
    localparam int         STEP_HZ_SRC1_SEL1 = 125_000;
    localparam int         DIV_SRC0_SEL0    = PCLK_HZ / STEP_HZ_SRC0_SEL0;
    localparam int         DIV_SRC0_SEL1    = PCLK_HZ / STEP_HZ_SRC0_SEL1;
    localparam int         DIV_SRC1_SEL0    = PCLK_HZ / STEP_HZ_SRC1_SEL0;
    localparam int         DIV_SRC1_SEL1    = PCLK_HZ / STEP_HZ_SRC1_SEL1;
    localparam int         DIV_W            = 12;
endpackage

// ==== tb_dual_fan_pwm_control.sv ====
// Testbench for the dual fan PWM block
`timescale 1ns/1ns
module tb_dual_fan_pwm_control;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [31:0] paddr = 0, pwdata = 0, prdata;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, out_a, out_b;
    int          fail_count = 0, total_checks = 0, cyc = 0, seed = 32'h5e25e2e5;
    int          ra, rb, pa, pb, ha, hb;
    logic [7:0]  mdl [int];
    logic [2:0]  ca [3] = '{3'b000, 3'b101, 3'b011};
    logic [2:0]  cb [3] = '{3'b111, 3'b010, 3'b100};
    always #20 pclk = ~pclk;
    dual_fan_pwm_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .fan_pwm_out_a(out_a), .fan_pwm_out_b(out_b));
    fan_model fan_a (.pclk(pclk), .pin(out_a), .rises(ra), .period(pa), .high(ha));
    fan_model fan_b (.pclk(pclk), .pin(out_b), .rises(rb), .period(pb), .high(hb));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (fail_count == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge pclk) if (++cyc == 95000) begin fail_count++; test_done; end
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin fail_count++; $display("mismatch %s exp %h seen %h", n, e, s); end
    endtask
    function automatic int dv(logic [2:0] k);
        return (25 << (2 * k[2] + k[1])) >> k[0];
    endfunction
    task automatic apb(logic w, logic [7:0] i, logic [31:0] d, logic [3:0] s,
                       output logic [31:0] r, output logic e);
        psel <= 1; pwrite <= w; paddr <= {22'h0, i, 2'b00}; pwdata <= d; pstrb <= s;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task automatic wr(logic [7:0] i, logic [31:0] d, logic [3:0] s = 4'hf);
        logic [31:0] r; logic e;
        apb(1, i, d, s, r, e);
        chk("write error", 32'(e), 32'(!(i inside {[8'h52:8'h58]})));
        if (s[0] && i inside {[8'h56:8'h58]}) mdl[i] = d[7:0];
    endtask
    task automatic rd(logic [7:0] i);
        logic [31:0] r; logic e;
        apb(0, i, 0, 0, r, e);
        chk("read data", r, mdl.exists(i) ? 32'(mdl[i]) : 32'h0);
        chk("read error", 32'(e), 32'(!(i inside {[8'h52:8'h58]})));
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] i; int du, c0, c1;
        mdl[8'h56] = 8'h00; mdl[8'h57] = 8'h00; mdl[8'h58] = 8'h50;
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (i = 8'h52; i <= 8'h58; i++) rd(i);
        repeat (40) begin
            i = 8'(8'h50 + $unsigned($random(seed)) % 12);
            wr(i, $random(seed), 4'($random(seed)));
            rd(i);
        end
        wr(8'h56, 32'h01); wr(8'h57, 32'h81);
        repeat (10) @(posedge pclk);
        chk("forced pins", {30'h0, out_a, out_b}, 32'h3);
        for (int c = 0; c < 3; c++) begin
            du = c == 0 ? 32 : c == 1 ? 63 : 1 + $unsigned($random(seed)) % 63;
            wr(8'h58, {24'h0, 4'h5, cb[c][0], ca[c][0], cb[c][2], ca[c][2]});
            wr(8'h56, {24'h0, ca[c][1], 6'(du), 1'b0});
            wr(8'h57, {24'h0, cb[c][1], 6'(64 - du), 1'b0});
            c0 = ra; c1 = rb;
            wait (ra >= c0 + 3 && rb >= c1 + 3);
            chk("period a", pa, 64 * dv(ca[c]));
            chk("high a", ha, du * dv(ca[c]));
            chk("period b", pb, 64 * dv(cb[c]));
            chk("high b", hb, (64 - du) * dv(cb[c]));
        end
        test_done;
    end
endmodule // tb_dual_fan_pwm_control
bind dual_fan_pwm_control fan_pwm_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .fan_pwm_out_a(fan_pwm_out_a),
    .fan_pwm_out_b(fan_pwm_out_b));
